// file: design/tmr8_pkg.sv
// Constants and types shared by the 8-bit waveform timer
package tmr8_pkg;
    localparam int DW = 32;
    localparam int AW = 5;

    // Register byte addresses
    localparam logic [AW-1:0] OFS_CTRL  = 5'h00;
    localparam logic [AW-1:0] OFS_CNT   = 5'h04;
    localparam logic [AW-1:0] OFS_CMP   = 5'h08;
    localparam logic [AW-1:0] OFS_ASYNC = 5'h0C;
    localparam logic [AW-1:0] OFS_FLAG  = 5'h10;

    // Control, async select and flag field positions
    localparam int CTRL_FORCE = 7;
    localparam int CTRL_WGM0  = 6;
    localparam int CTRL_COM1  = 5;
    localparam int CTRL_COM0  = 4;
    localparam int CTRL_WGM1  = 3;
    localparam int CTRL_CS_HI = 2;
    localparam int CTRL_CS_LO = 0;
    localparam int ASYNC_SEL  = 3;
    localparam int FLAG_TOV   = 0;
    localparam int FLAG_OCF   = 1;

    // Waveform modes
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_PCPWM  = 2'h1;
    localparam logic [1:0] MODE_CTC    = 2'h2;
    localparam logic [1:0] MODE_FAST   = 2'h3;

    // Compare output actions
    localparam logic [1:0] COM_OFF    = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR  = 2'h2;
    localparam logic [1:0] COM_SET    = 2'h3;

    // Clock select codes
    localparam logic [2:0] CS_STOP    = 3'h0;
    localparam logic [2:0] CS_DIV1    = 3'h1;
    localparam logic [2:0] CS_DIV8    = 3'h2;
    localparam logic [2:0] CS_DIV32   = 3'h3;
    localparam logic [2:0] CS_DIV64   = 3'h4;
    localparam logic [2:0] CS_DIV128  = 3'h5;
    localparam logic [2:0] CS_DIV256  = 3'h6;
    localparam logic [2:0] CS_DIV1024 = 3'h7;

    // Prescaler masks
    localparam int PW = 10;
    localparam logic [PW-1:0] MASK8    = 10'h007;
    localparam logic [PW-1:0] MASK32   = 10'h01F;
    localparam logic [PW-1:0] MASK64   = 10'h03F;
    localparam logic [PW-1:0] MASK128  = 10'h07F;
    localparam logic [PW-1:0] MASK256  = 10'h0FF;
    localparam logic [PW-1:0] MASK1024 = 10'h3FF;
    localparam logic [PW-1:0] PRE_ZERO = 10'h000;
    localparam logic [PW-1:0] PRE_ONE  = 10'h001;

    localparam logic [7:0] CNT_MAX    = 8'hFF;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_ONE    = 8'h01;
    localparam logic [7:0] RST_BYTE   = 8'h00;
    localparam logic [DW-1:0] RD_ZERO = 32'h0000_0000;

    typedef struct packed {
        logic          psel;
        logic          penable;
        logic          pwrite;
        logic [AW-1:0] paddr;
        logic [DW-1:0] pwdata;
    } tmr8_apb_req_t;

    typedef struct packed {
        logic          pready;
        logic          pslverr;
        logic [DW-1:0] prdata;
    } tmr8_apb_rsp_t;
endpackage

// file: design/tmr8_top.sv
// 8-bit timer with compare unit, waveform output and APB registers
//
// Summary of operation
// - Force strobe applies compare action in non-PWM
// - Forced compare sets no flag, no clear
// - Force bit always reads back zero
// - Mode bits six and three select mode/top
// - Compare buffering and overflow point per mode
// - Nonzero output action overrides port pin
// - Non-PWM: off, toggle, clear, set on match
// - Fast PWM: clear/set on match, inverse bottom
// - Fast PWM compare at top: bottom action only
// - Phase PWM: action by count direction
// - Phase PWM compare at top: act at top
// - Clock select: stop or divide by seven steps
// - Counter readable and writable at any time
// - Counter write blocks next tick's match
// - Compare continuously; match sets flag, output
// - Timer tick is enable on system clock
// - Async select picks oscillator input as source
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module tmr8_top
    import tmr8_pkg::*;
(
    // Clock and reset
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    // APB
    input  wire tmr8_pkg::tmr8_apb_req_t apb_req,
    output var  tmr8_pkg::tmr8_apb_rsp_t apb_rsp,
    // Pins
    input  wire logic                    timer_osc_input,
    input  wire logic                    port_dir_out,
    output logic                         waveform_output_pin,
    output logic                         waveform_output_en
);
    import tmr8_pkg::*;

    // Prescaler tap select
    function automatic logic pre_hit(input logic [2:0]    cs,
                                     input logic [PW-1:0] p);
        unique case (cs)
            CS_STOP:    pre_hit = 1'b0;
            CS_DIV1:    pre_hit = 1'b1;
            CS_DIV8:    pre_hit = (p & MASK8) == MASK8;
            CS_DIV32:   pre_hit = (p & MASK32) == MASK32;
            CS_DIV64:   pre_hit = (p & MASK64) == MASK64;
            CS_DIV128:  pre_hit = (p & MASK128) == MASK128;
            CS_DIV256:  pre_hit = (p & MASK256) == MASK256;
            CS_DIV1024: pre_hit = (p & MASK1024) == MASK1024;
        endcase
    endfunction

    // Mode from a control byte
    function automatic logic [1:0] mode_of(input logic [7:0] c);
        mode_of = {c[CTRL_WGM1], c[CTRL_WGM0]};
    endfunction

    function automatic logic is_pwm(input logic [1:0] m);
        is_pwm = (m == MODE_PCPWM) || (m == MODE_FAST);
    endfunction

    logic [7:0]    ctrl_q;
    logic [7:0]    cnt_q;
    logic [7:0]    ocr_q;
    logic [7:0]    ocr_buf_q;
    logic [PW-1:0] pre_q;
    logic          async_q;
    logic          osc_prev_q;
    logic          down_q;
    logic          block_q;
    logic          tov_q;
    logic          ocf_q;
    logic          out_q;
    logic          oe_q;
    tmr8_apb_rsp_t rsp_q;

    logic [1:0]    mode;
    logic [1:0]    com;
    logic [2:0]    cs;
    logic          acc;
    logic          done;
    logic          wr_ctrl;
    logic          wr_cnt;
    logic          wr_cmp;
    logic          wr_async;
    logic          wr_flag;
    logic          src_tick;
    logic          tick;
    logic          at_max;
    logic          at_bot;
    logic          match;
    logic          force_cmp;
    logic [1:0]    force_com;
    logic          tov_set;
    logic          ocr_load;
    logic          hit;
    logic [DW-1:0] rd_val;

    assign apb_rsp             = rsp_q;
    assign waveform_output_pin = out_q;
    assign waveform_output_en  = oe_q;

    // Decode and tick generation
    always_comb begin
        mode     = mode_of(ctrl_q);
        com      = ctrl_q[CTRL_COM1:CTRL_COM0];
        cs       = ctrl_q[CTRL_CS_HI:CTRL_CS_LO];
        acc      = apb_req.psel & apb_req.penable;
        done     = acc & rsp_q.pready & apb_req.pwrite;
        wr_ctrl  = done & (apb_req.paddr == OFS_CTRL);
        wr_cnt   = done & (apb_req.paddr == OFS_CNT);
        wr_cmp   = done & (apb_req.paddr == OFS_CMP);
        wr_async = done & (apb_req.paddr == OFS_ASYNC);
        wr_flag  = done & (apb_req.paddr == OFS_FLAG);
        src_tick = async_q ? (timer_osc_input & ~osc_prev_q) : 1'b1;
        tick     = src_tick & pre_hit(cs, pre_q);
        at_max   = cnt_q == CNT_MAX;
        at_bot   = cnt_q == CNT_BOTTOM;
        match    = tick & (cnt_q == ocr_q) & ~block_q;
        force_cmp = wr_ctrl & apb_req.pwdata[CTRL_FORCE]
                    & ~is_pwm(mode_of(apb_req.pwdata[7:0]));
        force_com = apb_req.pwdata[CTRL_COM1:CTRL_COM0];
        tov_set  = tick & ((mode == MODE_PCPWM) ? (down_q & at_bot)
                                                : at_max);
        ocr_load = tick & (((mode == MODE_PCPWM) & ~down_q & at_max)
                           | ((mode == MODE_FAST) & at_max));
        hit = 1'b1;
        rd_val = RD_ZERO;
        unique case (apb_req.paddr)
            OFS_CTRL:  rd_val[7:0] = {1'b0, ctrl_q[6:0]};
            OFS_CNT:   rd_val[7:0] = cnt_q;
            OFS_CMP:   rd_val[7:0] = ocr_buf_q;
            OFS_ASYNC: rd_val[ASYNC_SEL] = async_q;
            OFS_FLAG: begin
                rd_val[FLAG_TOV] = tov_q;
                rd_val[FLAG_OCF] = ocf_q;
            end
            default:   hit = 1'b0;
        endcase
    end

    // APB answer, one wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsp_q <= '0;
        end else begin
            rsp_q.pready  <= acc & ~rsp_q.pready;
            rsp_q.pslverr <= acc & ~rsp_q.pready & ~hit;
            if (acc & ~rsp_q.pready & ~apb_req.pwrite) begin
                rsp_q.prdata <= rd_val;
            end
        end
    end

    // Control and clock source registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q  <= RST_BYTE;
            async_q <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= {1'b0, apb_req.pwdata[6:0]};
            end
            if (wr_async) begin
                async_q <= apb_req.pwdata[ASYNC_SEL];
            end
        end
    end

    // Prescaler and oscillator edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q      <= PRE_ZERO;
            osc_prev_q <= 1'b0;
        end else begin
            osc_prev_q <= timer_osc_input;
            if (cs == CS_STOP) begin
                pre_q <= PRE_ZERO;
            end else if (src_tick) begin
                pre_q <= pre_q + PRE_ONE;
            end
        end
    end

    // Counter, direction and match blocking
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q   <= RST_BYTE;
            down_q  <= 1'b0;
            block_q <= 1'b0;
        end else begin
            if (wr_cnt) begin
                block_q <= 1'b1;
            end else if (tick) begin
                block_q <= 1'b0;
            end
            if (wr_cnt) begin
                cnt_q <= apb_req.pwdata[7:0];
            end else if (tick) begin
                unique case (mode)
                    MODE_CTC: begin
                        cnt_q <= match ? CNT_BOTTOM : cnt_q + CNT_ONE;
                    end
                    MODE_PCPWM: begin
                        if (!down_q && at_max) begin
                            cnt_q  <= cnt_q - CNT_ONE;
                            down_q <= 1'b1;
                        end else if (down_q && at_bot) begin
                            cnt_q  <= cnt_q + CNT_ONE;
                            down_q <= 1'b0;
                        end else if (down_q) begin
                            cnt_q <= cnt_q - CNT_ONE;
                        end else begin
                            cnt_q <= cnt_q + CNT_ONE;
                        end
                    end
                    default: begin
                        cnt_q <= cnt_q + CNT_ONE;
                    end
                endcase
            end
            if (mode != MODE_PCPWM) begin
                down_q <= 1'b0;
            end
        end
    end

    // Compare value and its buffer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ocr_q     <= RST_BYTE;
            ocr_buf_q <= RST_BYTE;
        end else begin
            if (wr_cmp) begin
                ocr_buf_q <= apb_req.pwdata[7:0];
            end
            if (wr_cmp && !is_pwm(mode)) begin
                ocr_q <= apb_req.pwdata[7:0];
            end else if (ocr_load) begin
                ocr_q <= ocr_buf_q;
            end
        end
    end

    // Sticky flags, write one to clear, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tov_q <= 1'b0;
            ocf_q <= 1'b0;
        end else begin
            tov_q <= tov_set
                     | (tov_q & ~(wr_flag & apb_req.pwdata[FLAG_TOV]));
            ocf_q <= match
                     | (ocf_q & ~(wr_flag & apb_req.pwdata[FLAG_OCF]));
        end
    end

    // Waveform output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_q <= 1'b0;
            oe_q  <= 1'b0;
        end else begin
            oe_q <= (com != COM_OFF) & port_dir_out;
            if (force_cmp) begin
                unique case (force_com)
                    COM_TOGGLE: out_q <= ~out_q;
                    COM_CLEAR:  out_q <= 1'b0;
                    COM_SET:    out_q <= 1'b1;
                    COM_OFF:    out_q <= out_q;
                endcase
            end else begin
                unique case (mode)
                    MODE_FAST: begin
                        if (com[1] && tick && at_max) begin
                            out_q <= ~com[0];
                        end else if (com[1] && match && ocr_q != CNT_MAX) begin
                            out_q <= com[0];
                        end
                    end
                    MODE_PCPWM: begin
                        if (com[1] && ocr_q == CNT_MAX) begin
                            if (tick && at_max && !down_q) begin
                                out_q <= ~com[0];
                            end
                        end else if (com[1] && match) begin
                            out_q <= down_q ? ~com[0] : com[0];
                        end
                    end
                    default: begin
                        if (match) begin
                            unique case (com)
                                COM_TOGGLE: out_q <= ~out_q;
                                COM_CLEAR:  out_q <= 1'b0;
                                COM_SET:    out_q <= 1'b1;
                                COM_OFF:    out_q <= out_q;
                            endcase
                        end
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// file: sim/tmr8_monitor.sv
// Port checker for the 8-bit waveform timer
`timescale 1ns/1ns
`default_nettype none
module tmr8_monitor
    import tmr8_pkg::*;
(
    // Clock and reset
    input wire logic                    pclk,
    input wire logic                    presetn,
    // Register bus
    input wire tmr8_pkg::tmr8_apb_req_t apb_req,
    input wire tmr8_pkg::tmr8_apb_rsp_t apb_rsp,
    // Pins
    input wire logic                    timer_osc_input,
    input wire logic                    port_dir_out,
    input wire logic                    waveform_output_pin,
    input wire logic                    waveform_output_en
);
    logic [7:0] ctrl_q;
    logic       hs;
    logic       cw;
    assign hs = apb_req.psel && apb_req.penable && apb_rsp.pready;
    assign cw = hs && apb_req.pwrite && apb_req.paddr == OFS_CTRL;
    // Mirror of the control byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= RST_BYTE;
        end else if (cw) begin
            ctrl_q <= {1'b0, apb_req.pwdata[6:0]};
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_access;
        apb_req.psel && !apb_req.penable ##1 apb_req.psel && apb_req.penable;
    endsequence
    sequence s_force;
        cw && apb_req.pwdata[7] && !apb_req.pwdata[6]
            && apb_req.pwdata[2:0] == CS_STOP && ctrl_q[2:0] == CS_STOP;
    endsequence
    a_ready_timing: assert property (s_access |-> !apb_rsp.pready ##1 apb_rsp.pready)
        else $error("pready not one cycle into access");
    a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("pready longer than one cycle");
    a_ctrl_read: assert property (hs && !apb_req.pwrite && apb_req.paddr == OFS_CTRL
        |-> apb_rsp.prdata == {24'h000000, ctrl_q})
        else $error("control read back wrong");
    a_read_upper: assert property (hs && !apb_req.pwrite |-> apb_rsp.prdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    a_slverr_map: assert property (hs && apb_req.paddr[1:0] == 2'h0
        |-> apb_rsp.pslverr == (apb_req.paddr > OFS_FLAG))
        else $error("pslverr wrong for address");
    a_enable_follows: assert property (1'b1 |-> waveform_output_en
        == $past(ctrl_q[5:4] != COM_OFF && port_dir_out))
        else $error("pin enable wrong");
    a_stop_stable: assert property ((ctrl_q[2:0] == CS_STOP && !cw) [*4]
        |-> $stable(waveform_output_pin))
        else $error("pin moved while stopped");
    a_force_toggle: assert property (s_force ##0 apb_req.pwdata[5:4] == COM_TOGGLE
        |-> (##1 $changed(waveform_output_pin)) or (##2 $changed(waveform_output_pin)))
        else $error("forced toggle missing");
    a_force_level: assert property (s_force ##0 apb_req.pwdata[5]
        |-> ##[1:2] waveform_output_pin == ctrl_q[CTRL_COM0])
        else $error("forced set or clear missing");
endmodule
bind tmr8_top tmr8_monitor i_mon (.pclk(pclk), .presetn(presetn),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .timer_osc_input(timer_osc_input),
    .port_dir_out(port_dir_out), .waveform_output_pin(waveform_output_pin),
    .waveform_output_en(waveform_output_en));
`default_nettype wire

// file: sim/tb_async_capable_timer8_waveform.sv
// Self-checking bench for the 8-bit waveform timer
`timescale 1ns/1ns
`default_nettype none
module tb_async_capable_timer8_waveform;
    import tmr8_pkg::*;
    logic          pclk, presetn, osc, dir, pin, en;
    tmr8_apb_req_t req;
    tmr8_apb_rsp_t rsp;
    int            n_errors, n_tests, seed, hi, w;
    logic [7:0]    s;
    logic [32:0]   expq[$];
    logic [4:0]    adr[5] = '{OFS_CTRL, OFS_CNT, OFS_CMP, OFS_ASYNC, OFS_FLAG};
    int            dv[7] = '{1, 8, 32, 64, 128, 256, 1024};
    logic [7:0]    pm[4] = '{8'h69, 8'h69, 8'h61, 8'h61};
    logic [7:0]    pc[4] = '{8'h80, 8'hFF, 8'h40, 8'hFF};
    int            ph[4] = '{1024, 2048, 514, 2048};
    tmr8_top i_dut (.pclk(pclk), .presetn(presetn), .apb_req(req),
        .apb_rsp(rsp), .timer_osc_input(osc), .port_dir_out(dir),
        .waveform_output_pin(pin), .waveform_output_en(en));
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    task automatic chk(string nm, logic [32:0] e, logic [32:0] g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic complete_run();
        if (n_errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic apb(logic wr_n, logic [4:0] a, logic [7:0] d, logic [32:0] e);
        int t;
        req.psel <= 1'b1;
        req.pwrite <= wr_n;
        req.paddr <= a;
        req.pwdata <= {24'h000000, d};
        if (!wr_n) expq.push_back(e);
        @(posedge pclk);
        req.penable <= 1'b1;
        t = 0;
        do begin
            @(posedge pclk);
            t++;
        end while (!rsp.pready && t < 50);
        if (t >= 50) chk("pready", 1, 0);
        req <= '0;
        @(posedge pclk);
    endtask
    task automatic wr(logic [4:0] a, logic [7:0] d);
        apb(1'b1, a, d, '0);
    endtask
    task automatic rd(logic [4:0] a, logic [7:0] d, logic err = 1'b0);
        apb(1'b0, a, 8'h00, {err, 24'h000000, d});
    endtask
    task automatic osc_edges(int n);
        repeat (n) begin
            repeat (3) @(posedge pclk);
            osc <= 1'b1;
            repeat (3) @(posedge pclk);
            osc <= 1'b0;
        end
        repeat (4) @(posedge pclk);
    endtask
    // Read results against the oldest note
    always @(negedge pclk) begin
        if (rsp.pready && !req.pwrite && expq.size() > 0) begin
            chk("read", expq.pop_front(), {rsp.pslverr, rsp.prdata});
        end
    end
    initial begin
        repeat (80000) @(posedge pclk);
        n_errors++;
        complete_run();
    end
    initial begin
        seed = 38;
        n_errors = 0;
        n_tests = 0;
        {presetn, osc, dir} = 3'h1;
        req = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (adr[i]) rd(adr[i], 8'h00);
        rd(5'h14, 8'h00, 1'b1);
        // Forced compare actions while stopped
        wr(OFS_CTRL, 8'h90);
        chk("pin", 1, pin);
        wr(OFS_CTRL, 8'hB0);
        chk("pin", 1, pin);
        wr(OFS_CTRL, 8'hA8);
        chk("pin", 0, pin);
        chk("en", 1, en);
        rd(OFS_CTRL, 8'h28);
        rd(OFS_FLAG, 8'h00);
        rd(OFS_CNT, 8'h00);
        dir <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("en", 0, en);
        // Overflow and match in normal mode
        wr(OFS_CTRL, 8'h00);
        wr(OFS_CNT, 8'hF0);
        wr(OFS_CTRL, 8'h01);
        repeat (40) @(posedge pclk);
        wr(OFS_CTRL, 8'h00);
        rd(OFS_FLAG, 8'h03);
        wr(OFS_FLAG, 8'h03);
        rd(OFS_FLAG, 8'h00);
        // Prescaler steps
        for (int i = 1; i < 7; i++) begin
            s = 8'($random(seed));
            wr(OFS_CNT, s);
            wr(OFS_CTRL, 8'(i + 1));
            w = 4 * dv[i] + dv[i] / 2 - 4;
            repeat (w) @(posedge pclk);
            wr(OFS_CTRL, 8'h00);
            rd(OFS_CNT, s + 8'h04);
        end
        // Clear on match never overflows
        wr(OFS_FLAG, 8'h03);
        wr(OFS_CMP, 8'h05);
        wr(OFS_CNT, 8'h00);
        wr(OFS_CTRL, 8'h09);
        repeat (300) @(posedge pclk);
        wr(OFS_CTRL, 8'h00);
        rd(OFS_FLAG, 8'h02);
        // Duty of the two PWM modes
        foreach (pm[i]) begin
            wr(OFS_CTRL, 8'h00);
            wr(OFS_CMP, pc[i]);
            wr(OFS_CNT, 8'($random(seed)));
            wr(OFS_CTRL, pm[i]);
            repeat (600) @(posedge pclk);
            hi = 0;
            repeat (2048) begin
                @(posedge pclk);
                hi += int'(pin);
            end
            chk("duty", 1, hi >= ph[i] - 16 && hi <= ph[i] + 16);
        end
        // Oscillator clocking and write-blocked match
        wr(OFS_CTRL, 8'h00);
        wr(OFS_FLAG, 8'h03);
        wr(OFS_ASYNC, 8'h08);
        rd(OFS_ASYNC, 8'h08);
        wr(OFS_CMP, 8'h03);
        wr(OFS_CTRL, 8'h11);
        wr(OFS_CNT, 8'h03);
        osc_edges(1);
        rd(OFS_FLAG, 8'h00);
        wr(OFS_CNT, 8'h02);
        osc_edges(2);
        rd(OFS_FLAG, 8'h02);
        osc_edges(5);
        rd(OFS_CNT, 8'h09);
        complete_run();
    end
endmodule
`default_nettype wire
